// [shared/sess_pkg.sv]
// Constants for the serial edge select and status front end
package sess_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int CH_NUM = 4;          // Number of playback channels
	localparam int CH_IDX_W = 2;        // Width of a channel index
	localparam int CMD_W = 8;           // Bits in one command byte
	localparam int BIT_CNT_W = 3;       // Width of the bit counter
	localparam int PIN_NUM = 4;         // Pins passed through the synchroniser

	// ****************************************
	// Positions inside the synchronised pin vector
	// ****************************************
	localparam int PIN_EDGE_SEL = 0;    // Edge select strap
	localparam int PIN_CS_N = 1;        // Chip select, active low
	localparam int PIN_SCK = 2;         // Host serial clock
	localparam int PIN_SDI = 3;         // Host serial data in

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic STATUS_RST = 1'b1;       // Status pin after reset
	localparam logic ERROR_RST = 1'b0;        // Error pin after reset
	localparam logic CMD_BUSY_N_RST = 1'b1;   // Command busy, idle after reset
	localparam logic SDO_IDLE = 1'b1;         // Serial out filler level
	localparam logic EDGE_SEL_RISE = 1'b0;    // Strap level: capture on rise
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7; // Last bit of a byte

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100; // Block clock period
	localparam int SCK_MIN_PERIOD_NS = 800; // Fastest safe serial clock
	localparam int SCK_MIN_CYCLES = SCK_MIN_PERIOD_NS / CLK_PERIOD_NS;

	// Which indication the status pin shows
	typedef enum logic {
		SESS_STAT_BUSY = 1'b0,
		SESS_STAT_READY = 1'b1
	} sess_stat_t;

endpackage : sess_pkg

// [src/sess_sync.sv]
// Two flip-flop synchroniser for a group of pins
module sess_sync #(
	parameter int W = 4
) (
	// Clock
	input wire logic clk,
	// Asynchronous pins in, synchronised copies out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import sess_pkg::*;

	logic [W-1:0] meta_q; // First stage, read only by the second

	// ****************************************
	// Two stages per bit
	// ****************************************
	// No reset: pins must keep flowing while reset stands, so the
	// strap can be caught and chip select reads idle during reset
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end

endmodule : sess_sync

// [src/sess_front.sv]
// Serial command front end with edge select, status and error pins
module sess_front (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host serial pins
	input wire logic serial_edge_select,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	output logic command_busy_n,
	// Status and error pins
	output logic status_pin,
	output logic error_pin,
	// Received command bytes toward the decoder
	output logic [sess_pkg::CMD_W-1:0] rx_data,
	output logic rx_valid,
	// Decoder and core side
	input wire logic core_busy,
	input wire logic status_output_command,
	input wire sess_pkg::sess_stat_t stat_sel,
	input wire logic [sess_pkg::CH_IDX_W-1:0] stat_chan,
	input wire logic error_event,
	input wire logic error_clear,
	input wire logic [sess_pkg::CH_NUM-1:0] channel_busy_n,
	input wire logic [sess_pkg::CH_NUM-1:0] channel_next_ready
);
	import sess_pkg::*;

	// ****************************************
	// Pin synchronisation and edge finding
	// ****************************************
	logic [PIN_NUM-1:0] pins_s;         // Synchronised pins
	logic sck_prev_q;                   // Serial clock one cycle back
	logic cs_n_prev_q;                  // Chip select one cycle back
	logic edge_sel_q;                   // Strap caught during reset

	sess_sync #(
		.W(PIN_NUM)
	) u_sync (
		.clk(clk),
		.d({sdi, sck, chip_select_n, serial_edge_select}),
		.q(pins_s)
	);

	wire cs_n_s = pins_s[PIN_CS_N];
	wire sck_s = pins_s[PIN_SCK];
	wire sdi_s = pins_s[PIN_SDI];
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;
	wire cs_fall = cs_n_prev_q & ~cs_n_s;
	wire strap_rise = (edge_sel_q == EDGE_SEL_RISE);
	// Capture and output edges are always opposite ones
	wire cap_edge = ~cs_n_s & (strap_rise ? sck_rise : sck_fall);
	wire out_edge = ~cs_n_s & (strap_rise ? sck_fall : sck_rise);

	// Edge history; the strap is taken while reset stands and held after, so
	// a change of strap mid-frame cannot split a byte
	always_ff @(posedge clk) begin
		sck_prev_q <= sck_s;
		cs_n_prev_q <= rst ? 1'b1 : cs_n_s;
		if (rst) begin
			edge_sel_q <= pins_s[PIN_EDGE_SEL];
		end
	end

	// ****************************************
	// Command byte capture
	// ****************************************
	logic [CMD_W-1:0] shift_q;          // Bits gathered so far, first bit high
	logic [BIT_CNT_W-1:0] bit_cnt_q;    // Bits taken in this byte
	logic [CMD_W-1:0] rx_data_q;        // Last whole byte
	logic rx_valid_q;                   // One-cycle byte strobe

	wire [CMD_W-1:0] shift_d = {shift_q[CMD_W-2:0], sdi_s};
	wire byte_done = cap_edge & (bit_cnt_q == LAST_BIT);

	// Chip select high clears a partial byte and ignores the clock
	always_ff @(posedge clk) begin
		if (rst || cs_n_s) begin
			bit_cnt_q <= '0;
			shift_q <= '0;
		end else if (cap_edge) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q <= shift_d;
		end
	end

	// Byte hand-off to the decoder
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_data_q <= '0;
			rx_valid_q <= 1'b0;
		end else begin
			rx_valid_q <= byte_done;
			if (byte_done) begin
				rx_data_q <= shift_d;
			end
		end
	end

	assign rx_data = rx_data_q;
	assign rx_valid = rx_valid_q;

	// ****************************************
	// Command busy
	// ****************************************
	logic command_busy_n_q;             // Low from a byte until core idle

	// Goes low the cycle after a byte lands, so the host sees it
	// before the core has even begun
	always_ff @(posedge clk) begin
		if (rst) begin
			command_busy_n_q <= CMD_BUSY_N_RST;
		end else begin
			command_busy_n_q <= ~(byte_done | core_busy);
		end
	end

	assign command_busy_n = command_busy_n_q;

	// ****************************************
	// Status selection
	// ****************************************
	sess_stat_t stat_sel_q;             // Indication chosen by the command
	logic [CH_IDX_W-1:0] stat_chan_q;   // Channel shown on the status pin
	logic stat_on_q;                    // Status command seen since reset
	logic status_pin_q;                 // Status pin flop

	// Per-channel vector of the chosen indication
	wire [CH_NUM-1:0] stat_vec =
		(stat_sel_q == SESS_STAT_READY) ? channel_next_ready : channel_busy_n;
	wire stat_pick = stat_vec[stat_chan_q]; // Chosen channel's indication

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_sel_q <= SESS_STAT_BUSY;
			stat_chan_q <= '0;
			stat_on_q <= 1'b0;
			status_pin_q <= STATUS_RST;
		end else begin
			if (status_output_command) begin
				stat_sel_q <= stat_sel;
				stat_chan_q <= stat_chan;
				stat_on_q <= 1'b1;
			end
			// Tracks the channel live once enabled
			status_pin_q <= stat_on_q ? stat_pick : STATUS_RST;
		end
	end

	assign status_pin = status_pin_q;

	// ****************************************
	// Serial status output
	// ****************************************
	logic [CH_NUM-1:0] tx_q;            // Snapshot rotating toward bit 0
	logic sdo_q;                        // Serial output flop

	// Snapshot at chip select fall so a frame shows one instant.
	// With falling-edge output the first bit is up before the first
	// clock; with rising-edge output it appears on the first rise.
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_q <= '0;
			sdo_q <= SDO_IDLE;
		end else if (cs_fall) begin
			if (strap_rise) begin
				sdo_q <= stat_vec[0];
				tx_q <= {stat_vec[0], stat_vec[CH_NUM-1:1]};
			end else begin
				sdo_q <= SDO_IDLE;
				tx_q <= stat_vec;
			end
		end else if (out_edge) begin
			sdo_q <= tx_q[0];
			tx_q <= {tx_q[0], tx_q[CH_NUM-1:1]};
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = ~cs_n_s;

	// ****************************************
	// Error pin
	// ****************************************
	logic error_q;                      // Sticky error flag

	// A new error beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			error_q <= ERROR_RST;
		end else if (error_event) begin
			error_q <= 1'b1;
		end else if (error_clear) begin
			error_q <= 1'b0;
		end
	end

	assign error_pin = error_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	cap_rise_a: assert property (
		(cap_edge && !edge_sel_q) |-> (sck_rise && !cs_n_s))
		else $error("capture not on rising edge with strap low");

	out_fall_a: assert property (
		($changed(sdo_q) && !$past(cs_fall) && !edge_sel_q)
		|-> $past(sck_fall))
		else $error("output change not on falling edge with strap low");

	cap_fall_a: assert property (
		(edge_sel_q && !cs_n_s && sck_fall) |=>
		(bit_cnt_q != $past(bit_cnt_q) || cs_n_s))
		else $error("falling edge not captured with strap high");

	out_rise_a: assert property (
		(out_edge && edge_sel_q) |-> (sck_rise && !cap_edge))
		else $error("output edge not rising with strap high");

	stat_show_a: assert property (
		(status_output_command ##1 !status_output_command)
		|=> status_pin_q == $past(stat_pick))
		else $error("status pin not showing chosen channel");

	err_set_a: assert property (
		error_event |=> error_pin)
		else $error("error pin not high after error");

	stat_reset_a: assert property (
		!stat_on_q |-> status_pin)
		else $error("status pin not one after reset");

	cs_ignore_a: assert property (
		cs_n_s |=> (bit_cnt_q == '0 && !rx_valid_q) ##1 !byte_done[*1])
		else $error("clock or data taken with chip select high");

	sdo_float_a: assert property (
		cs_n_s |-> !sdo_oe)
		else $error("serial output driven with chip select high");

	busy_low_a: assert property (
		byte_done |=> !command_busy_n ##0 rx_valid)
		else $error("command busy not low after command byte");

	err_cause_a: assert property (
		$rose(error_pin) |-> $past(error_event))
		else $error("error pin rose without an error");

	byte_cov: cover property (rx_valid && edge_sel_q == EDGE_SEL_RISE);
	byte_fall_cov: cover property (rx_valid && edge_sel_q != EDGE_SEL_RISE);
	stat_cov: cover property (stat_on_q && !status_pin);
	err_cov: cover property (error_event && error_clear);

endmodule : sess_front

// [tb/sess_host_model.sv]
// Host CPU model driving the serial command pins
module sess_host_model (
	// Block clock used to pace the pins
	input wire logic clk,
	// Serial pins toward the device
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo,
	input wire logic busy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Deselected, link clock parked low outside frames
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// Half of the 800 ns link period
	task automatic half();
		repeat (4) @(posedge clk);
	endtask : half
	// Send n bits MSB first; read sdo just before each fall
	task automatic xfer(input logic [7:0] b, input int n,
		output logic [7:0] so);
		so = 8'h00;
		// New command only while the device is idle; watchdog bounds it
		while (busy_n !== 1'b1) begin
			@(posedge clk);
		end
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			// Data moves mid-low, clear of both clock edges
			repeat (2) @(posedge clk);
			sdi <= b[7-i];
			repeat (2) @(posedge clk);
			sck <= 1'b1;
			half();
			so[7-i] = sdo;
			sck <= 1'b0;
		end
		half();
		cs_n <= 1'b1;
		// Released data line must not keep its last value
		sdi <= ~sdi;
		// Deselect gap so a following frame starts with a fresh fall
		half();
	endtask : xfer
	// Clock and data wiggle while deselected; eight full clocks,
	// enough to make a byte if chip select were not honoured
	task automatic noise();
		repeat (16) begin
			half();
			sck <= ~sck;
			sdi <= ~sdi;
		end
	endtask : noise
endmodule : sess_host_model

// [tb/serial_edge_select_status_tb.sv]
// Self-checking bench for the serial front end
module serial_edge_select_status_tb;
	import sess_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Signals
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic edge_sel = 1'b0;
	logic cs_n, sck, sdi, sdo, sdo_oe, sdo_w, cbusy_n;
	logic status_pin, error_pin, rx_valid, core_busy = 1'b0;
	logic [7:0] rx_data, rx_got;
	logic stat_cmd = 1'b0;
	sess_stat_t stat_sel = SESS_STAT_BUSY;
	logic [1:0] stat_chan = 2'h0;
	logic err_ev = 1'b0;
	logic err_clr = 1'b0;
	logic [3:0] busy_v = 4'h6;
	logic [3:0] ready_v = 4'h9;
	int n_fail = 0;
	int num_checks = 0;
	int n_rx = 0;
	// Floating pin shows the inverse so a missing enable is seen
	assign sdo_w = sdo_oe ? sdo : ~sdo;
	always #50 clk = ~clk;
	sess_front u_sess_front (.clk(clk), .rst(rst),
		.serial_edge_select(edge_sel), .chip_select_n(cs_n),
		.sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.command_busy_n(cbusy_n), .status_pin(status_pin),
		.error_pin(error_pin), .rx_data(rx_data),
		.rx_valid(rx_valid), .core_busy(core_busy),
		.status_output_command(stat_cmd), .stat_sel(stat_sel),
		.stat_chan(stat_chan), .error_event(err_ev),
		.error_clear(err_clr), .channel_busy_n(busy_v),
		.channel_next_ready(ready_v));
	sess_host_model u_sess_host_model (.clk(clk), .cs_n(cs_n),
		.sck(sck), .sdi(sdi), .sdo(sdo_w), .busy_n(cbusy_n));
	// Catch each one-cycle byte pulse
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			n_rx <= n_rx + 1;
			rx_got <= rx_data;
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	// Strap is taken while reset is held
	task automatic do_reset(input logic strap);
		rst <= 1'b1;
		edge_sel <= strap;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_reset
	task automatic stat(input logic s, input logic [1:0] c);
		stat_cmd <= 1'b1;
		stat_sel <= sess_stat_t'(s);
		stat_chan <= c;
		@(posedge clk);
		stat_cmd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : stat
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		do_reset(1'b0);
		check(status_pin, 1'b1);
		check(error_pin, 1'b0);
		check(sdo_oe, 1'b0);
		check(cbusy_n, 1'b1);
		$display("test reset done");
	endtask : t_reset
	// Aborted partial byte, then a full byte and status stream
	task automatic t_rx(input logic st, input logic [7:0] b,
		input logic [7:0] exp_so);
		logic [7:0] so;
		int n0;
		do_reset(st);
		stat(st, 2'h0);
		n0 = n_rx;
		u_sess_host_model.xfer(~b, 3, so);
		u_sess_host_model.xfer(b, 8, so);
		repeat (4) @(posedge clk);
		check(8'(n_rx - n0), 8'h01);
		check(rx_got, b);
		check(so, exp_so);
		check(sdo_oe, 1'b0);
		$display("test rx strap %0d done", st);
	endtask : t_rx
	task automatic t_noise();
		int n0;
		n0 = n_rx;
		u_sess_host_model.noise();
		repeat (6) @(posedge clk);
		check(8'(n_rx - n0), 8'h00);
		$display("test deselected done");
	endtask : t_noise
	// Every indication kind on every channel
	task automatic t_status();
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 4; c++) begin
				stat(s[0], c[1:0]);
				check(status_pin, s ? ready_v[c] : busy_v[c]);
			end
		end
		$display("test status done");
	endtask : t_status
	task automatic t_busy();
		core_busy <= 1'b1;
		repeat (3) @(posedge clk);
		check(cbusy_n, 1'b0);
		core_busy <= 1'b0;
		repeat (3) @(posedge clk);
		check(cbusy_n, 1'b1);
		$display("test busy done");
	endtask : t_busy
	// Set wins over a clear in the same cycle
	task automatic t_err();
		err_ev <= 1'b1;
		err_clr <= 1'b1;
		@(posedge clk);
		err_ev <= 1'b0;
		err_clr <= 1'b0;
		repeat (2) @(posedge clk);
		check(error_pin, 1'b1);
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		repeat (2) @(posedge clk);
		check(error_pin, 1'b0);
		$display("test error done");
	endtask : t_err
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		t_reset();
		t_rx(1'b0, 8'ha5, 8'h66);
		t_rx(1'b1, 8'h3c, 8'h99);
		t_noise();
		t_status();
		t_busy();
		t_err();
		tally_and_finish();
	end
	// Watchdog, far beyond the few hundred cycles expected
	initial begin
		#2000000;
		n_fail++;
		tally_and_finish();
	end
endmodule : serial_edge_select_status_tb
